/* File: prom_xfer_pkg.sv */
// Purpose: Shared constants and types for the PROM program/verify/transfer controller
// Assumes: 16-bit host memory addresses, 8-bit data, 16-bit PROM addresses
// Notes: Register offsets are byte addresses of one-word registers
package prom_xfer_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LOW = 8'h04;
	localparam logic [7:0] OFS_HIGH = 8'h08;
	localparam logic [7:0] OFS_PADDR = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_EVENT = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
	localparam logic [7:0] OFS_ERR_ADDR = 8'h20;
	localparam logic [7:0] OFS_MISMATCH = 8'h24;
	localparam logic [7:0] OFS_PROM_SIZE = 8'h28;

	// Control register fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_SOCK_LSB = 2;
	localparam int CTRL_POL_BIT = 4;
	localparam int CTRL_GO_BIT = 5;

	// Event bits
	localparam int EV_DONE = 0;
	localparam int EV_ERR = 1;
	localparam int EV_MISMATCH = 2;
	localparam int EV_W = 3;

	// Reset values
	localparam logic [ADDR_W-1:0] PROM_SIZE_RST = 16'h0100;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		OP_PROGRAM = 2'b00,
		OP_COMPARE = 2'b01,
		OP_TRANSFER = 2'b10,
		OP_NONE = 2'b11
	} op_t;

	typedef enum logic [1:0] {
		SOCK_TWO = 2'b00,
		SOCK_ONE_HIGH = 2'b01,
		SOCK_ONE_LOW = 2'b10,
		SOCK_RSVD = 2'b11
	} sock_t;

	// Request to the programming unit
	typedef struct packed {
		logic req;
		logic write;
		logic socketTwo;
		logic [1:0] nibble;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} unit_req_t;

	// Request to host memory
	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} mem_req_t;

	// One compare mismatch record
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] memByte;
		logic [DATA_W-1:0] promByte;
	} mismatch_t;

endpackage

/* File: sync2.sv */
// Purpose: Two flip-flop synchroniser for a level from outside the clock domain
// Assumes: Input changes slowly compared with ref_clk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module sync2 (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic stage1;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= 1'b0;
			dout <= 1'b0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule // sync2

/* File: prom_xfer.sv */
// What this block does
// - Socket-two code addresses socket 2, data handled as full bytes.
// - Upper-nibble code addresses socket 1, PROM word maps to bits 7-4.
// - Lower-nibble code addresses socket 1, PROM word maps to bits 3-0.
// - True polarity: PROM bits equal memory bits.
// - False polarity: PROM data is the inverse of memory data everywhere.
// - Start while unit not ready raises an error at once, no operation.
// - Program sends low..high bytes, first at given PROM address.
// - False polarity program inverts bytes sent, memory never written.
// - Every programmed location gets a full eight-bit byte.
// - Unit verify failure: report PROM address with error, stop.
// - Compare reports address, memory byte and PROM byte, then continues.
// - Compare reads eight bits, masks memory to selected nibble.
// - Transfer stops when range is filled, rest of PROM ignored.
// - Range beyond PROM: copy all PROM data, leave rest, flag error.
// - False polarity transfer inverts received bytes before storing.
// - Transfer stores full bytes at consecutive increasing addresses.
// - Low above high acts on the single location at low.
//
// Purpose: Controller moving data between host memory and a two-socket PROM unit
// Assumes: Memory answers reads one cycle after the read request
// Notes: Unit ready, ack, verify error and read data are pins and pass two flops
`timescale 1ns/1ps
module prom_xfer
	import prom_xfer_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	output logic irq,
	// Host memory
	output mem_req_t memReq,
	input wire logic [DATA_W-1:0] memRdata,
	// Programming unit
	output unit_req_t unitReq,
	input wire logic unitReady,
	input wire logic unitAck,
	input wire logic unitVerifyErr,
	input wire logic [DATA_W-1:0] unitRdata,
	// Compare mismatch stream
	output mismatch_t mismatch,
	output logic mismatchValid
);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_MEM_RD = 3'b001,
		ST_MEM_WAIT = 3'b010,
		ST_UNIT = 3'b011,
		ST_UNIT_DONE = 3'b100,
		ST_NEXT = 3'b101
	} state_t;

	// Memory-side view of a PROM byte and back again
	function automatic logic [DATA_W-1:0] polarity(input logic [DATA_W-1:0] d, input logic inv);
		polarity = inv ? ~d : d;
	endfunction

	function automatic logic [DATA_W-1:0] nibbleMask(input sock_t s);
		case (s)
			SOCK_ONE_HIGH: nibbleMask = 8'hf0;
			SOCK_ONE_LOW: nibbleMask = 8'h0f;
			default: nibbleMask = 8'hff;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic readySync;
	logic ackSync;
	logic verifyErrSync;

	sync2 uReady (.ref_clk(ref_clk), .rst_n(rst_n), .din(unitReady), .dout(readySync));
	sync2 uAck (.ref_clk(ref_clk), .rst_n(rst_n), .din(unitAck), .dout(ackSync));
	sync2 uVerr (.ref_clk(ref_clk), .rst_n(rst_n), .din(unitVerifyErr), .dout(verifyErrSync));

	// The unit holds its data while ack stands, so the bits settle in step with ackSync
	logic [DATA_W-1:0] rdataSync;

	for (genvar b = 0; b < DATA_W; b++) begin : gRdataSync
		sync2 uRdata (.ref_clk(ref_clk), .rst_n(rst_n), .din(unitRdata[b]),
			.dout(rdataSync[b]));
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	op_t op;
	sock_t sock;
	logic invert;
	logic [ADDR_W-1:0] lowAddr;
	logic [ADDR_W-1:0] highAddr;
	logic [ADDR_W-1:0] promStart;
	logic [ADDR_W-1:0] promSize;
	logic [ADDR_W-1:0] errAddr;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] irqEn;
	state_t state;
	logic [ADDR_W-1:0] memPtr;
	logic [ADDR_W-1:0] promPtr;
	logic [ADDR_W-1:0] lastAddr;
	logic [DATA_W-1:0] memByte;

	logic wrHit;
	logic goWrite;
	logic startOk;
	logic startRefused;
	logic [EV_W-1:0] evSet;
	logic busy;

	assign wrHit = regWr && (regAddr == OFS_CTRL);
	assign goWrite = wrHit && regWdata[CTRL_GO_BIT];
	assign busy = (state != ST_IDLE);
	assign startOk = goWrite && !busy && readySync && (op_t'(regWdata[CTRL_OP_LSB +: 2]) != OP_NONE);
	assign startRefused = goWrite && !busy && !readySync;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			op <= OP_NONE;
			sock <= SOCK_TWO;
			invert <= 1'b0;
			lowAddr <= '0;
			highAddr <= '0;
			promStart <= '0;
			promSize <= PROM_SIZE_RST;
			irqEn <= '0;
		end else if (regWr && !busy) begin
			case (regAddr)
				OFS_CTRL: begin
					op <= op_t'(regWdata[CTRL_OP_LSB +: 2]);
					sock <= sock_t'(regWdata[CTRL_SOCK_LSB +: 2]);
					invert <= regWdata[CTRL_POL_BIT];
				end
				OFS_LOW: lowAddr <= regWdata[ADDR_W-1:0];
				OFS_HIGH: highAddr <= regWdata[ADDR_W-1:0];
				OFS_PADDR: promStart <= regWdata[ADDR_W-1:0];
				OFS_PROM_SIZE: promSize <= regWdata[ADDR_W-1:0];
				OFS_IRQ_EN: irqEn <= regWdata[EV_W-1:0];
				default: ;
			endcase
		end else if (regWr && regAddr == OFS_IRQ_EN) begin
			irqEn <= regWdata[EV_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	logic rangeEnd;
	logic promEnd;
	logic [DATA_W-1:0] fromUnit;
	logic [DATA_W-1:0] mask;

	assign rangeEnd = (memPtr == lastAddr);
	assign promEnd = (promPtr == promSize - 16'h0001);
	assign fromUnit = polarity(rdataSync, invert);
	assign mask = nibbleMask(sock);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			memPtr <= '0;
			promPtr <= '0;
			lastAddr <= '0;
			memByte <= '0;
			memReq <= '0;
			unitReq <= '0;
			mismatch <= '0;
			mismatchValid <= 1'b0;
			errAddr <= '0;
			evSet <= '0;
		end else begin
			memReq.rd <= 1'b0;
			memReq.wr <= 1'b0;
			mismatchValid <= 1'b0;
			evSet <= '0;
			case (state)
				ST_IDLE: begin
					if (startOk) begin
						memPtr <= lowAddr;
						lastAddr <= (lowAddr > highAddr) ? lowAddr : highAddr;
						promPtr <= (op_t'(regWdata[CTRL_OP_LSB +: 2]) == OP_PROGRAM)
							? promStart : '0;
						unitReq.socketTwo <= (sock_t'(regWdata[CTRL_SOCK_LSB +: 2]) == SOCK_TWO);
						unitReq.nibble <= regWdata[CTRL_SOCK_LSB +: 2];
						state <= (op_t'(regWdata[CTRL_OP_LSB +: 2]) == OP_TRANSFER) ? ST_UNIT : ST_MEM_RD;
						unitReq.req <= (op_t'(regWdata[CTRL_OP_LSB +: 2]) == OP_TRANSFER);
						unitReq.write <= 1'b0;
						unitReq.addr <= '0;
					end else if (startRefused) begin
						evSet[EV_ERR] <= 1'b1;
					end
				end
				ST_MEM_RD: begin
					memReq.rd <= 1'b1;
					memReq.addr <= memPtr;
					state <= ST_MEM_WAIT;
				end
				ST_MEM_WAIT: begin
					// Memory answers in the cycle after the read pulse
					state <= ST_MEM_WAIT;
					if (!memReq.rd) begin
						memByte <= memRdata;
						unitReq.req <= 1'b1;
						unitReq.write <= (op == OP_PROGRAM);
						unitReq.addr <= promPtr;
						unitReq.data <= polarity(memRdata, invert);
						state <= ST_UNIT;
					end
				end
				ST_UNIT: begin
					if (ackSync) begin
						unitReq.req <= 1'b0;
						state <= ST_UNIT_DONE;
						if (op == OP_PROGRAM && verifyErrSync) begin
							errAddr <= promPtr;
							evSet[EV_ERR] <= 1'b1;
							state <= ST_NEXT;
							lastAddr <= memPtr;
						end else if (op == OP_COMPARE && ((fromUnit & mask) != (memByte & mask))) begin
							mismatch.addr <= memPtr;
							mismatch.memByte <= memByte;
							mismatch.promByte <= fromUnit;
							mismatchValid <= 1'b1;
							evSet[EV_MISMATCH] <= 1'b1;
						end else if (op == OP_TRANSFER) begin
							memReq.wr <= 1'b1;
							memReq.addr <= memPtr;
							memReq.data <= fromUnit;
						end
					end
				end
				ST_UNIT_DONE: begin
					// Wait for the unit to drop its acknowledge
					if (!ackSync) begin
						if (rangeEnd) begin
							state <= ST_IDLE;
							evSet[EV_DONE] <= 1'b1;
						end else if (op == OP_TRANSFER && promEnd) begin
							state <= ST_IDLE;
							evSet[EV_DONE] <= 1'b1;
							evSet[EV_ERR] <= 1'b1;
						end else begin
							memPtr <= memPtr + 16'h0001;
							promPtr <= promPtr + 16'h0001;
							if (op == OP_TRANSFER) begin
								unitReq.req <= 1'b1;
								unitReq.addr <= promPtr + 16'h0001;
								state <= ST_UNIT;
							end else begin
								state <= ST_MEM_RD;
							end
						end
					end
				end
				ST_NEXT: begin
					state <= ST_IDLE;
					evSet[EV_DONE] <= 1'b1;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Events and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			events <= '0;
		end else begin
			// Set wins over a clear in the same cycle
			if (regWr && regAddr == OFS_IRQ_CLR) begin
				events <= (events & ~regWdata[EV_W-1:0]) | evSet;
			end else begin
				events <= events | evSet;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(events & irqEn);
		end
	end

	// ----------------------------------------------------------------
	// Read data, one cycle after the read strobe
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= RDATA_RST;
		end else if (regRd) begin
			case (regAddr)
				OFS_CTRL: regRdata <= {26'h0, 1'b0, invert, sock, op};
				OFS_LOW: regRdata <= {16'h0, lowAddr};
				OFS_HIGH: regRdata <= {16'h0, highAddr};
				OFS_PADDR: regRdata <= {16'h0, promStart};
				OFS_STATUS: regRdata <= {29'h0, readySync, busy, 1'b0};
				OFS_EVENT: regRdata <= {29'h0, events};
				OFS_IRQ_EN: regRdata <= {29'h0, irqEn};
				OFS_ERR_ADDR: regRdata <= {16'h0, errAddr};
				OFS_MISMATCH: regRdata <= mismatch;
				OFS_PROM_SIZE: regRdata <= {16'h0, promSize};
				default: regRdata <= RDATA_RST;
			endcase
		end else begin
			regRdata <= RDATA_RST;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_REFUSE_ERR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		startRefused |=> evSet[EV_ERR] && state == ST_IDLE)
		else $error("refused start did not raise error");
	AST_NO_ADV: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == ST_UNIT && !ackSync) |=> $stable(memPtr))
		else $error("address advanced without acknowledge");
	AST_PROG_NO_MEMWR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(op == OP_PROGRAM && busy) |-> !memReq.wr)
		else $error("program wrote memory");
	AST_PROG_INV: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == ST_MEM_WAIT && !memReq.rd && op == OP_PROGRAM)
		|=> unitReq.data == (invert ? ~memByte : memByte))
		else $error("programmed byte polarity wrong");
	AST_VERR_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == ST_UNIT && ackSync && op == OP_PROGRAM && verifyErrSync)
		|=> errAddr == $past(promPtr) ##1 state == ST_IDLE)
		else $error("verify failure not reported");
	AST_MISMATCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mismatchValid |-> ((mismatch.promByte & mask) != (mismatch.memByte & mask)))
		else $error("false mismatch");
	AST_XFER_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == ST_UNIT && ackSync && op == OP_TRANSFER)
		|=> memReq.wr && memReq.data == $past(fromUnit))
		else $error("transfer byte not stored");
	AST_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		memReq.wr |-> memReq.addr <= lastAddr)
		else $error("write beyond range");
	AST_SOCKET: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(busy && sock == SOCK_TWO) |-> unitReq.socketTwo)
		else $error("socket two not addressed");

endmodule // prom_xfer

/* File: prom_unit_model.sv */
// Purpose: Behavioural programming unit on the far side of prom_xfer
// Assumes: One 256-byte part per run; both sockets hold eight-bit parts
// Notes: Ack comes after a short or a long wait, picked by slow
`timescale 1ns/1ps
module prom_unit_model
	import prom_xfer_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire unit_req_t unitReq,
	input wire logic readyIn,
	input wire logic slow,
	input wire logic failEn,
	input wire logic [ADDR_W-1:0] failAddr,
	output logic unitReady,
	output logic unitAck,
	output logic unitVerifyErr,
	output logic [DATA_W-1:0] unitRdata
);
	logic [DATA_W-1:0] prom [256];
	int cnt;
	// ----------------------------------------
	// Handshake and storage
	// ----------------------------------------
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			unitAck <= 1'b0;
			unitVerifyErr <= 1'b0;
			unitRdata <= 8'h5a;
			unitReady <= 1'b0;
			cnt <= 0;
		end else begin
			unitReady <= readyIn;
			if (unitReq.req && !unitAck) begin
				if (cnt >= (slow ? 6 : 1)) begin
					unitAck <= 1'b1;
					cnt <= 0;
					if (unitReq.write) begin
						// All eight bits are kept: no four-bit part is fitted
						prom[unitReq.addr[7:0]] <= unitReq.data;
						unitVerifyErr <= failEn && (unitReq.addr == failAddr);
						unitRdata <= unitReq.data;
					end else begin
						unitRdata <= prom[unitReq.addr[7:0]];
					end
				end else begin
					cnt <= cnt + 1;
				end
			end else if (!unitReq.req && unitAck) begin
				unitAck <= 1'b0;
				unitVerifyErr <= 1'b0;
				// Data no longer held once ack is gone
				unitRdata <= ~unitRdata;
			end
		end
	end
endmodule // prom_unit_model

/* File: prom_xfer_tb_top.sv */
// Purpose: Self-checking bench for prom_xfer
// Assumes: Host memory is modelled here with one cycle read latency
// Notes: PROM contents are preset and inspected through the model
`timescale 1ns/1ps
module prom_xfer_tb_top;
	import prom_xfer_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, irq;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata, ev;
	mem_req_t memReq;
	unit_req_t unitReq;
	mismatch_t mismatch;
	logic [DATA_W-1:0] memRdata = 8'h00, unitRdata;
	logic mismatchValid, unitReady, unitAck, unitVerifyErr;
	logic readyIn = 1'b0, slow = 1'b0, failEn = 1'b0, prevReq = 1'b0, lastS2;
	logic [1:0] lastNib;
	logic [ADDR_W-1:0] failAddr = 16'h0062;
	logic [7:0] mem [256];
	int mismatches = 0, samples_checked = 0, reqs = 0, mms = 0;
	mismatch_t lastMm;
	always #10 ref_clk = ~ref_clk;
	prom_xfer dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .memReq(memReq),
		.memRdata(memRdata), .unitReq(unitReq), .unitReady(unitReady), .unitAck(unitAck),
		.unitVerifyErr(unitVerifyErr), .unitRdata(unitRdata), .mismatch(mismatch),
		.mismatchValid(mismatchValid));
	prom_unit_model u_unit (.ref_clk(ref_clk), .rst_n(rst_n), .unitReq(unitReq),
		.readyIn(readyIn), .slow(slow), .failEn(failEn), .failAddr(failAddr),
		.unitReady(unitReady), .unitAck(unitAck), .unitVerifyErr(unitVerifyErr),
		.unitRdata(unitRdata));
	// ----------------------------------------
	// Host memory and observers
	// ----------------------------------------
	always @(posedge ref_clk) begin
		memRdata <= memReq.rd ? mem[memReq.addr[7:0]] : ~memRdata;
		if (memReq.wr)
			mem[memReq.addr[7:0]] <= memReq.data;
		prevReq <= unitReq.req;
		if (unitReq.req && !prevReq) begin
			reqs <= reqs + 1;
			lastS2 <= unitReq.socketTwo;
			lastNib <= unitReq.nibble;
		end
		if (mismatchValid) begin
			mms <= mms + 1;
			lastMm <= mismatch;
		end
	end
	// ----------------------------------------
	// Bus tasks and compare
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(negedge ref_clk);
		d = regRdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic run(input logic [1:0] op, sk, input logic pol, input logic [15:0] lo, hi, pa);
		wr(OFS_LOW, {16'h0, lo});
		wr(OFS_HIGH, {16'h0, hi});
		wr(OFS_PADDR, {16'h0, pa});
		wr(OFS_IRQ_CLR, 32'h7);
		wr(OFS_CTRL, 32'h20 | {27'h0, pol, sk, op});
		for (int i = 0; i < 300; i++) begin
			rd(OFS_EVENT, ev);
			if (ev[EV_DONE] === 1'b1)
				break;
		end
		chk({31'h0, ev[EV_DONE]}, 32'h1, "done");
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_notready();
		int r0;
		r0 = reqs;
		wr(OFS_IRQ_EN, 32'h2);
		wr(OFS_CTRL, 32'h20);
		repeat (4) @(posedge ref_clk);
		rd(OFS_EVENT, ev);
		chk({30'h0, ev[1:0]}, 32'h2, "not ready err");
		chk(reqs, r0, "no unit traffic");
		chk({31'h0, irq}, 32'h1, "irq up");
		wr(OFS_IRQ_CLR, 32'h7);
		repeat (2) @(negedge ref_clk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rd(OFS_STATUS + 8'h40, ev);
		chk(ev, 32'h0, "unmapped read");
		$display("test notready done");
	endtask
	task automatic t_program();
		mem[16] = 8'h11;
		mem[17] = 8'h22;
		mem[18] = 8'h33;
		mem[19] = 8'h44;
		rd(OFS_STATUS, ev);
		chk(ev, 32'h4, "ready and idle");
		run(OP_PROGRAM, SOCK_TWO, 1'b0, 16'h10, 16'h13, 16'h5);
		for (int i = 0; i < 4; i++)
			chk(u_unit.prom[5 + i], mem[16 + i], "programmed byte");
		chk(u_unit.prom[9], 8'h09, "past range untouched");
		chk({31'h0, lastS2}, 32'h1, "socket two");
		chk({30'h0, ev[1:0]}, 32'h1, "no error");
		mem[33] = 8'h5a;
		run(OP_PROGRAM, SOCK_ONE_HIGH, 1'b1, 16'h21, 16'h20, 16'h40);
		chk(u_unit.prom[64], 8'ha5, "inverted byte");
		chk(u_unit.prom[65], 8'h41, "single location");
		chk(mem[33], 8'h5a, "source kept");
		chk({31'h0, lastS2}, 32'h0, "socket one");
		chk({30'h0, lastNib}, {30'h0, SOCK_ONE_HIGH}, "upper nibble");
		$display("test program done");
	endtask
	task automatic t_verify();
		failEn <= 1'b1;
		run(OP_PROGRAM, SOCK_TWO, 1'b0, 16'h10, 16'h13, 16'h60);
		rd(OFS_ERR_ADDR, ev);
		chk(ev, 32'h62, "err address");
		rd(OFS_EVENT, ev);
		chk({31'h0, ev[EV_ERR]}, 32'h1, "verify err");
		chk(u_unit.prom[99], 8'h63, "stopped");
		failEn <= 1'b0;
		$display("test verify done");
	endtask
	task automatic t_compare();
		mem[48] = 8'hf0;
		mem[49] = 8'ha5;
		mem[50] = 8'h3c;
		mem[51] = 8'h07;
		u_unit.prom[0] = 8'hf0;
		u_unit.prom[1] = 8'ha0;
		u_unit.prom[2] = 8'h40;
		u_unit.prom[3] = 8'h10;
		slow <= 1'b1;
		run(OP_COMPARE, SOCK_ONE_HIGH, 1'b0, 16'h30, 16'h33, 16'h0);
		slow <= 1'b0;
		chk(mms, 2, "mismatch count");
		chk(lastMm.addr, 16'h33, "continued to last");
		chk(lastMm.promByte, 8'h10, "prom byte");
		chk(lastMm.memByte, 8'h07, "memory byte");
		chk({31'h0, ev[EV_MISMATCH]}, 32'h1, "mismatch event");
		rd(OFS_MISMATCH, ev);
		chk(ev, {16'h0033, 8'h07, 8'h10}, "mismatch record");
		$display("test compare done");
	endtask
	task automatic t_transfer();
		run(OP_TRANSFER, SOCK_ONE_LOW, 1'b1, 16'h50, 16'h53, 16'h0);
		chk({mem[80], mem[81], mem[82], mem[83]}, 32'h0f5fbfef, "inverted copy");
		chk(mem[84], 8'h00, "range filled only");
		chk({30'h0, ev[1:0]}, 32'h1, "short range ok");
		chk({31'h0, lastS2}, 32'h0, "socket one low");
		chk({30'h0, lastNib}, {30'h0, SOCK_ONE_LOW}, "lower nibble");
		wr(OFS_PROM_SIZE, 32'h2);
		run(OP_TRANSFER, SOCK_TWO, 1'b0, 16'h70, 16'h74, 16'h0);
		chk({mem[112], mem[113], mem[114]}, 24'hf0a000, "copy then stop");
		chk({31'h0, ev[EV_ERR]}, 32'h1, "too long err");
		$display("test transfer done");
	endtask
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'h00;
			u_unit.prom[i] = 8'(i);
		end
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_notready();
		readyIn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_program();
		t_verify();
		t_compare();
		t_transfer();
		end_of_test();
	end
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end
endmodule // prom_xfer_tb_top
